// File: include/scp_pkg.sv
// shared constants and carrier types for the serial command port
package scp_pkg;
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned BAUD         = 9600;
  localparam int unsigned OVS          = 16;
  localparam int unsigned TICK_DIV     = CLK_HZ / (BAUD * OVS);
  localparam int unsigned DATA_BITS    = 7;
  localparam int unsigned FRAME_BITS   = 10;
  localparam int unsigned OVS_MID      = OVS / 2;
  localparam int unsigned RESP_MS      = 10;
  localparam int unsigned RESP_CYC     = CLK_HZ / 1000 * RESP_MS;
  localparam logic [6:0]  CHAR_CR      = 7'h0D;
  localparam logic [6:0]  CHAR_LF      = 7'h0A;
  localparam logic [6:0]  CHAR_QUERY   = 7'h3F;
  localparam logic        LINE_IDLE    = 1'b1;
  localparam logic        BIT_START    = 1'b0;
  localparam logic        BIT_STOP     = 1'b1;

  // received character with status
  typedef struct packed {
    logic [6:0] data;
    logic       par_err;
    logic       frm_err;
    logic       eom;
  } scp_rx_char_t;

  // one-hot receiver and transmitter states
  typedef enum logic [2:0] {
    SCP_RX_IDLE  = 3'b001,
    SCP_RX_START = 3'b010,
    SCP_RX_SHIFT = 3'b100
  } scp_rx_st_t;

  typedef enum logic [2:0] {
    SCP_TX_IDLE = 3'b001,
    SCP_TX_WAIT = 3'b010,
    SCP_TX_SEND = 3'b100
  } scp_tx_st_t;
endpackage : scp_pkg

// File: design/scp_serial_port.sv
// serial command port: receiver, transmitter and half-duplex control
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module scp_serial_port #(
  parameter int unsigned TICK_DIV_P = scp_pkg::TICK_DIV,
  parameter int unsigned RESP_CYC_P = scp_pkg::RESP_CYC
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  ce_i,
  input  wire logic                  panel_busy_i,
  input  wire logic                  rxd_i,
  output logic                       txd_o,
  output scp_pkg::scp_rx_char_t      rx_char_o,
  output logic                       rx_valid_o,
  output logic                       query_pending_o,
  input  wire logic                  resp_valid_i,
  input  wire logic [6:0]            resp_data_i,
  output logic                       resp_ready_o,
  output logic                       tx_busy_o
);
  import scp_pkg::*;

  localparam int unsigned DW = $clog2(TICK_DIV_P + 1);
  localparam int unsigned RW = $clog2(RESP_CYC_P + 1);

  ////////////////////////////////////////////////////////////////////////////
  // operating notes for whoever picks this block up next
  //
  // timing base
  // - one shared divider makes sixteen ticks per bit
  // - the divider runs free, so a frame may start mid tick
  // - worst case phase error is one tick, well inside half a bit
  // - default divider gives a rate a hair above nominal
  // - simulation shrinks the divider to keep runs short
  //
  // receive path
  // - line is taken as already synchronous to mclk_i
  // - an outer synchroniser is the user's job if the pin is raw
  // - a low level while idle arms the start check
  // - start is confirmed at half a bit, else it was a glitch
  // - data, parity and stop are sampled at their centres
  // - bits arrive least significant first
  // - a bad parity or stop still delivers the character
  // - the flags travel beside the data, software decides
  // - rx_valid_o is a single cycle pulse
  // - rx_char_o holds until the next character lands
  //
  // message tracking
  // - a carriage return arms the end-of-message detector
  // - only a line feed right after it closes the message
  // - any question mark with good parity inside marks a query
  // - a question mark with bad parity is not trusted
  // - commands alone never wake the transmitter
  //
  // transmit path
  // - armed only by a closed message that held a query
  // - the response source offers one character at a time
  // - resp_ready_o is combinational from the state register and panel_busy_i
  // - the start bit goes out on the edge after the hand-over
  // - after each stop bit the response window opens again
  // - the response ends when no character comes in time
  // - the window is the typical answer delay of the device
  //
  // half duplex and muting
  // - the receiver is parked while the transmitter is busy
  // - front-panel setup parks the receiver as well
  // - panel setup also drops a response still waiting
  // - a frame already on the wire is still finished
  // - bytes sent by the host during a response are lost
  //
  // limitations
  // - no flow control pins exist, pacing is the host's duty
  // - no buffering: the consumer must take each pulse
  // - no break detection, a stuck low line rearms each frame
  // - after a bad stop bit the next low may look like a start
  //
  // clock enable
  // - ce_i low freezes every register, divider included
  // - combinational outputs still follow the frozen state

  // odd parity bit for seven data bits
  function automatic logic odd_par(input logic [6:0] d);
    odd_par = ~(^d);
  endfunction : odd_par

  ////////////////////////////////////////////////////////////////////////////
  // oversample tick, sixteen per bit
  logic [DW-1:0] div_q;
  logic          tick;
  assign tick = (div_q == DW'(TICK_DIV_P - 1));

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= '0;
    end else if (ce_i) begin
      div_q <= tick ? '0 : div_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver
  // idle: wait for a low line with the receiver enabled
  // start: count half a bit, confirm the line is still low
  // shift: one sample every sixteen ticks, nine in total
  // the last sample is the stop bit and closes the frame
  // dropping rx_enable at any point abandons the frame,
  // so a partly heard character is never delivered
  scp_rx_st_t  rx_st_q;
  logic [3:0]  rx_ovs_q;
  logic [3:0]  rx_bit_q;
  logic [8:0]  rx_sh_q;
  logic        tx_active;
  logic        rx_enable;
  logic        cr_seen_q;
  logic        has_query_q;

  // panel work or our own transmission mutes the receiver
  assign rx_enable = !panel_busy_i && !tx_active;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_st_q    <= SCP_RX_IDLE;
      rx_ovs_q   <= '0;
      rx_bit_q   <= '0;
      rx_sh_q    <= '0;
      rx_valid_o <= 1'b0;
      rx_char_o  <= '0;
    end else if (ce_i) begin
      rx_valid_o <= 1'b0;
      case (rx_st_q)
        SCP_RX_IDLE: begin
          rx_ovs_q <= '0;
          if (rx_enable && rxd_i == BIT_START) begin
            rx_st_q <= SCP_RX_START;
          end
        end
        SCP_RX_START: begin
          if (!rx_enable) begin
            rx_st_q <= SCP_RX_IDLE;
          end else if (tick) begin
            if (rx_ovs_q == 4'(OVS_MID - 1)) begin
              rx_ovs_q <= '0;
              // glitch shorter than half a bit is ignored
              rx_st_q  <= (rxd_i == BIT_START) ? SCP_RX_SHIFT : SCP_RX_IDLE;
              rx_bit_q <= '0;
            end else begin
              rx_ovs_q <= rx_ovs_q + 1'b1;
            end
          end
        end
        SCP_RX_SHIFT: begin
          if (!rx_enable) begin
            rx_st_q <= SCP_RX_IDLE;
          end else if (tick) begin
            rx_ovs_q <= rx_ovs_q + 1'b1;
            if (rx_ovs_q == 4'(OVS - 1)) begin
              if (rx_bit_q == 4'(FRAME_BITS - 2)) begin
                rx_st_q <= SCP_RX_IDLE;
                rx_valid_o <= 1'b1;
                rx_char_o.data <= rx_sh_q[7:1];
                rx_char_o.par_err <=
                  (rx_sh_q[8] != odd_par(rx_sh_q[7:1]));
                rx_char_o.frm_err <= (rxd_i != BIT_STOP);
                rx_char_o.eom <= cr_seen_q &&
                  (rx_sh_q[7:1] == CHAR_LF);
              end else begin
                rx_sh_q  <= {rxd_i, rx_sh_q[8:1]};
                rx_bit_q <= rx_bit_q + 1'b1;
              end
            end
          end
        end
        default: rx_st_q <= SCP_RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // message tracking: CR then LF closes, a '?' marks a query
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cr_seen_q   <= 1'b0;
      has_query_q <= 1'b0;
    end else if (ce_i && rx_valid_o) begin
      if (rx_char_o.eom) begin
        cr_seen_q   <= 1'b0;
        has_query_q <= 1'b0;
      end else begin
        cr_seen_q <= (rx_char_o.data == CHAR_CR);
        if (rx_char_o.data == CHAR_QUERY && !rx_char_o.par_err) begin
          has_query_q <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter, armed only by a completed query message
  // idle: line high, window counter cleared
  // wait: offer ready, count the response window
  // send: shift the ten frame bits, sixteen ticks each
  // after the stop bit the block returns to wait, so
  // back to back characters cost one extra cycle only
  // a response ends by letting the window run out
  scp_tx_st_t  tx_st_q;
  logic [RW-1:0] wait_q;
  logic [3:0]  tx_ovs_q;
  logic [3:0]  tx_bit_q;
  logic [9:0]  tx_sh_q;
  logic        resp_done;

  assign tx_active       = (tx_st_q != SCP_TX_IDLE);
  assign tx_busy_o       = tx_active;
  assign query_pending_o = tx_active;
  assign resp_done = (tx_st_q == SCP_TX_SEND) && tick &&
                     tx_ovs_q == 4'(OVS - 1) &&
                     tx_bit_q == 4'(FRAME_BITS - 1);
  // the response source is pulled only between characters
  assign resp_ready_o = (tx_st_q == SCP_TX_WAIT) && !panel_busy_i;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_st_q  <= SCP_TX_IDLE;
      wait_q   <= '0;
      tx_ovs_q <= '0;
      tx_bit_q <= '0;
      tx_sh_q  <= {FRAME_BITS{LINE_IDLE}};
      txd_o    <= LINE_IDLE;
    end else if (ce_i) begin
      case (tx_st_q)
        SCP_TX_IDLE: begin
          txd_o  <= LINE_IDLE;
          wait_q <= '0;
          if (rx_valid_o && rx_char_o.eom && has_query_q
              && !panel_busy_i) begin
            tx_st_q <= SCP_TX_WAIT;
          end
        end
        SCP_TX_WAIT: begin
          // the response window closes if nothing comes in time
          if (resp_valid_i && resp_ready_o) begin
            tx_sh_q  <= {BIT_STOP, odd_par(resp_data_i), resp_data_i,
                         BIT_START};
            tx_ovs_q <= '0;
            tx_bit_q <= '0;
            txd_o    <= BIT_START;
            tx_st_q  <= SCP_TX_SEND;
          end else if (panel_busy_i ||
                       wait_q == RW'(RESP_CYC_P - 1)) begin
            tx_st_q <= SCP_TX_IDLE;
          end else begin
            wait_q <= wait_q + 1'b1;
          end
        end
        SCP_TX_SEND: begin
          txd_o <= tx_sh_q[0];
          if (tick) begin
            tx_ovs_q <= tx_ovs_q + 1'b1;
            if (tx_ovs_q == 4'(OVS - 1)) begin
              tx_sh_q  <= {LINE_IDLE, tx_sh_q[9:1]};
              tx_bit_q <= tx_bit_q + 1'b1;
            end
          end
          if (resp_done) begin
            wait_q  <= '0;
            tx_st_q <= SCP_TX_WAIT;
          end
        end
        default: tx_st_q <= SCP_TX_IDLE;
      endcase
    end
  end
endmodule : scp_serial_port

// File: tb/scp_port_props.sv
// checker for the serial command port
`timescale 1ns/100ps
module scp_port_props
  import scp_pkg::*;
(
  input wire logic         mclk_i,
  input wire logic         rst_n_i,
  input wire logic         ce_i,
  input wire logic         panel_busy_i,
  input wire logic         rxd_i,
  input wire logic         txd_o,
  input wire scp_rx_char_t rx_char_o,
  input wire logic         rx_valid_o,
  input wire logic         query_pending_o,
  input wire logic         resp_valid_i,
  input wire logic [6:0]   resp_data_i,
  input wire logic         resp_ready_o,
  input wire logic         tx_busy_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  //////////////////////////////////////////////////////////////////////////////
  // the line only leaves idle to answer a query
  a_idle_line: assert property (
    !tx_busy_o |-> txd_o) else $error("line left idle");
  a_half_duplex: assert property (
    tx_busy_o |-> !rx_valid_o) else $error("rx while sending");
  a_pending_busy: assert property (
    query_pending_o == tx_busy_o) else $error("pending mismatch");
  a_ready_busy: assert property (
    resp_ready_o |-> tx_busy_o) else $error("ready while idle");
  a_start_bit: assert property (
    resp_valid_i && resp_ready_o |=> !txd_o && !resp_ready_o)
    else $error("no start bit");
  // short check only: a full bit is far longer than eight cycles
  a_start_hold: assert property (
    $fell(txd_o) |-> !txd_o[*8]) else $error("start bit short");
  a_panel_mute: assert property (
    panel_busy_i && $past(panel_busy_i) |-> !rx_valid_o)
    else $error("rx during panel setup");
  a_valid_pulse: assert property (
    rx_valid_o |=> !rx_valid_o) else $error("valid not a pulse");
endmodule : scp_port_props

// File: tb/scp_host_model.sv
// host-side serial model: sends and receives framed characters
`timescale 1ns/100ps
module scp_host_model #(
  parameter int BIT = 64
) (
  input  wire logic mclk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  initial rxd_o = 1'b1; // idle high
  //////////////////////////////////////////////////////////////////////////////
  // start, d0..d6, odd parity, stop; bp and bs break parity and stop
  task automatic send(input logic [6:0] c, input logic bp, input logic bs);
    logic [9:0] f;
    f = {~bs, (~^c) ^ bp, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_o = f[i];
      repeat (BIT) @(negedge mclk_i);
    end
    rxd_o = 1'b1;
  endtask : send
  // bounded wait for a start bit, then sample each bit centre
  task automatic recv(output logic [9:0] f, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 4000 && !ok; n++) begin
      @(negedge mclk_i);
      ok = !txd_i;
    end
    repeat (BIT / 2) @(negedge mclk_i);
    for (int i = 0; i < 10; i++) begin
      f[i] = txd_i;
      repeat (BIT) @(negedge mclk_i);
    end
  endtask : recv
endmodule : scp_host_model

// File: tb/tb_top.sv
// testbench for the serial command port
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
  miscompares++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
  import scp_pkg::*;
  localparam int BIT = 4 * OVS;
  typedef struct packed {
    logic [6:0] c; logic bp; logic bs; scp_rx_char_t e;
  } scp_row_t;
  logic mclk_i = 0, rst_n_i = 0, panel = 0, rvld = 0;
  logic rxd, txd, rv, rdy, busy, qp, ok;
  logic [6:0] rdat = '0;
  logic [9:0] fr;
  scp_rx_char_t rch, got;
  int checks = 0, miscompares = 0, nrx = 0, n0;
  // rows: sent char, broken parity and stop, expected status
  scp_row_t rows[5] = '{
    '{7'h41, 1'b0, 1'b0, '{7'h41, 1'b0, 1'b0, 1'b0}},
    '{7'h5A, 1'b1, 1'b0, '{7'h5A, 1'b1, 1'b0, 1'b0}},
    '{7'h31, 1'b0, 1'b1, '{7'h31, 1'b0, 1'b1, 1'b0}},
    '{7'h0D, 1'b0, 1'b0, '{7'h0D, 1'b0, 1'b0, 1'b0}},
    '{7'h0A, 1'b0, 1'b0, '{7'h0A, 1'b0, 1'b0, 1'b1}}};
  // one short query, no chaining, well under 64 chars
  logic [6:0] qry[5] = '{7'h41, CHAR_QUERY, 7'h20, CHAR_CR, CHAR_LF};
  //////////////////////////////////////////////////////////////////////////////
  scp_serial_port #(.TICK_DIV_P(4), .RESP_CYC_P(2000)) DUT (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .panel_busy_i(panel), .rxd_i(rxd), .txd_o(txd), .rx_char_o(rch),
    .rx_valid_o(rv), .query_pending_o(qp), .resp_valid_i(rvld),
    .resp_data_i(rdat), .resp_ready_o(rdy), .tx_busy_o(busy));
  scp_host_model #(.BIT(BIT)) host (.mclk_i(mclk_i), .txd_i(txd),
    .rxd_o(rxd));
  initial forever #2 mclk_i = ~mclk_i;
  // latch each delivered char
  always @(posedge mclk_i) if (rv === 1'b1) begin
    got <= rch;
    nrx <= nrx + 1;
  end
  task automatic print_verdict();
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (12) @(negedge mclk_i);
    rst_n_i = 1;
    `CHK("txd idle", 1'b1, txd)
    `CHK("valid", 1'b0, rv)
    // idle gap after each row lets a broken stop bit settle
    foreach (rows[i]) begin
      host.send(rows[i].c, rows[i].bp, rows[i].bs);
      `CHK("rx char", rows[i].e, got)
      repeat (12 * BIT) @(negedge mclk_i);
    end
    `CHK("no query busy", 1'b0, busy)
    // one burst with terminators, sent back to back with no gaps
    foreach (qry[i]) host.send(qry[i], 1'b0, 1'b0);
    @(negedge mclk_i);
    `CHK("busy", 1'b1, busy)
    `CHK("ready", 1'b1, rdy)
    n0 = nrx;
    host.send(7'h42, 1'b0, 1'b0);
    `CHK("rx muted", n0, nrx)
    fork
      host.recv(fr, ok);
      begin
        rvld = 1;
        rdat = 7'h4B;
        @(posedge mclk_i);
        @(negedge mclk_i) rvld = 0;
      end
    join
    `CHK("tx ok", 1'b1, ok)
    `CHK("tx frame", {1'b1, ~^7'h4B, 7'h4B, 1'b0}, fr)
    if (!ok) print_verdict();
    // host stays silent until the response is over
    for (int n = 0; n < 3000 && busy; n++) @(negedge mclk_i);
    `CHK("idle", 1'b0, busy)
    if (busy !== 1'b0) print_verdict();
    panel = 1;
    n0 = nrx;
    host.send(7'h42, 1'b0, 1'b0);
    `CHK("panel mute", n0, nrx)
    print_verdict();
  end
endmodule : tb_top
bind scp_serial_port scp_port_props u_props (.mclk_i(mclk_i),
  .rst_n_i(rst_n_i), .ce_i(ce_i), .panel_busy_i(panel_busy_i),
  .rxd_i(rxd_i), .txd_o(txd_o), .rx_char_o(rx_char_o),
  .rx_valid_o(rx_valid_o), .query_pending_o(query_pending_o),
  .resp_valid_i(resp_valid_i), .resp_data_i(resp_data_i),
  .resp_ready_o(resp_ready_o), .tx_busy_o(tx_busy_o));
